// ---- rtl/eips_top.v ----
/*
 External interrupt pin selection: select registers on the secondary
 bus, per-pin enables, edge detection and pending flags.
 Assumes a single-cycle secondary bus write/read strobe on clk_sys and
 pins that are asynchronous to clk_sys.
*/
`timescale 1ns/10ps
`default_nettype none
`include "eips_consts.vh"
module eips_top
(
   // Clock and reset
   input wire clk_sys,
   input wire nrst,
   // Secondary register bus
   input wire [7:0] sbus_addr,
   input wire sbus_wr,
   input wire sbus_rd,
   input wire [7:0] sbus_wdata,
   output reg [7:0] sbus_rdata_q,
   // Pending flag clears from the interrupt status logic
   input wire [8:0] group0_clr,
   input wire line_clr,
   input wire shared_clr,
   // Pins
   input wire [3:1] line_pins,
   input wire [8:0] group0_pins,
   input wire [22:0] shared_group_inputs,
   // Routed enables and events
   output reg [3:1] line_pin_enable_q,
   output reg [8:0] group0_member_enable_q,
   output reg [22:0] shared_group_pin_enable_q,
   output reg [3:1] line_req_q,
   output reg [8:0] group0_pending_q,
   output reg shared_req_q
);
   localparam NPIN = 35;
   localparam [7:0] RST_POL2 = `EIPS_RST_POL2;

   reg [7:0] sel_main_q;
   reg [7:0] sel_g0_q;
   reg [7:0] sel_g4l_q;
   reg [7:0] sel_g4m_q;
   reg [7:0] sel_g4h_q;
   reg [7:0] pol1_q;
   reg [2:0] pol2_q;
   reg [NPIN-1:0] meta_q;
   reg [NPIN-1:0] sync_q;
   reg shared_busy_q;
   reg [4:0] shared_idx_q;
   wire [NPIN-1:0] pins;
   wire [NPIN-1:0] en;
   wire [2*NPIN-1:0] pol;
   wire [NPIN-1:0] hit;
   wire [22:0] shared_en;
   wire [8:0] g0_en;
   wire [3:1] line_en;
   reg [7:0] rd_d;
   reg [1:0] arm_q;
   wire armed;

   function wr_hit;
      input [7:0] a;
      begin
         wr_hit = sbus_wr && (sbus_addr == a);
      end
   endfunction

   // Register writes; reserved bits of the shared group and POL2 registers held at zero
   always @(posedge clk_sys)
   begin
      if (!nrst)
      begin
         sel_main_q <= `EIPS_RST_MAIN;
         sel_g0_q <= `EIPS_RST_G0;
         sel_g4l_q <= `EIPS_RST_G4_LOW;
         sel_g4m_q <= `EIPS_RST_G4_MID;
         sel_g4h_q <= `EIPS_RST_G4_HIGH;
         pol1_q <= `EIPS_RST_POL1;
         pol2_q <= RST_POL2[2:0];
      end
      else
      begin
         if (wr_hit(`EIPS_ADDR_MAIN))
            sel_main_q <= sbus_wdata;
         if (wr_hit(`EIPS_ADDR_G0))
            sel_g0_q <= sbus_wdata;
         if (wr_hit(`EIPS_ADDR_G4_LOW))
            sel_g4l_q <= sbus_wdata & `EIPS_MASK_G4_LOW;
         if (wr_hit(`EIPS_ADDR_G4_MID))
            sel_g4m_q <= sbus_wdata & `EIPS_MASK_G4_MID;
         if (wr_hit(`EIPS_ADDR_G4_HIGH))
            sel_g4h_q <= sbus_wdata & `EIPS_MASK_G4_HIGH;
         if (wr_hit(`EIPS_ADDR_POL1))
            pol1_q <= sbus_wdata;
         if (wr_hit(`EIPS_ADDR_POL2))
            pol2_q <= sbus_wdata[2:0];
      end
   end

   assign line_en = {sel_main_q[`EIPS_BIT_LINE3],
                     sel_main_q[`EIPS_BIT_LINE2],
                     sel_main_q[`EIPS_BIT_LINE1]};
   assign g0_en = {sel_main_q[`EIPS_BIT_G0P8], sel_g0_q};
   // Member pins 11..14 and 0..6 have no select bit and stay off
   assign shared_en = {sel_g4h_q[6:0], sel_g4m_q[7], 4'h0, sel_g4m_q[2:0],
                       sel_g4l_q[7], 7'h00};

   assign pins = {shared_group_inputs, group0_pins, line_pins};
   // No pin is live until synchroniser and history hold real pin levels;
   // otherwise the reset zeros look like an edge on an idle-high pin
   assign en = {shared_en, g0_en, line_en} & {NPIN{armed}};

   always @(posedge clk_sys)
   begin
      if (!nrst)
         arm_q <= 2'h0;
      else if (!armed)
         arm_q <= arm_q + 2'h1;
   end
   assign armed = (arm_q == 2'h3);

   // Polarity codes per pin; the shared group uses a one-bit select
   genvar i;
   generate
      for (i = 0; i < NPIN; i = i + 1)
      begin : g_pin
         if (i < 3)
            assign pol[2*i+1:2*i] = pol1_q[2*i+3:2*i+2];
         else if (i == 11)
            assign pol[2*i+1:2*i] = pol1_q[1:0];
         else if (i < 11)
            assign pol[2*i+1:2*i] = pol2_q[1:0];
         else
            assign pol[2*i+1:2*i] = pol2_q[`EIPS_BIT_G4_POL] ?
                                    `EIPS_POL_RISE : `EIPS_POL_FALL;
         eips_edge u_edge
         (
            .clk_sys(clk_sys),
            .nrst(nrst),
            .pin_sync(sync_q[i]),
            .enable(en[i]),
            .polarity(pol[2*i+1:2*i]),
            .hit(hit[i])
         );
      end
   endgenerate

   // Two-stage synchroniser on every pin
   always @(posedge clk_sys)
   begin
      if (!nrst)
      begin
         meta_q <= {NPIN{1'b0}};
         sync_q <= {NPIN{1'b0}};
      end
      else
      begin
         meta_q <= pins;
         sync_q <= meta_q;
      end
   end

   // First member hit when the shared vector is free
   function [5:0] first_hit;
      input [22:0] h;
      integer k;
      begin
         first_hit = 6'h00;
         for (k = 22; k >= 0; k = k - 1)
            if (h[k])
               first_hit = {1'b1, k[4:0]};
      end
   endfunction

   wire [5:0] shared_pick;
   wire shared_idle;
   assign shared_pick = first_hit(hit[NPIN-1:12]);
   // Idle level is high for a falling trigger, low for a rising one
   assign shared_idle = pol2_q[`EIPS_BIT_G4_POL] ?
                        ~sync_q[12 + shared_idx_q] :
                        sync_q[12 + shared_idx_q];

   always @(posedge clk_sys)
   begin
      if (!nrst)
      begin
         line_req_q <= 3'h0;
         group0_pending_q <= 9'h000;
         shared_req_q <= 1'b0;
         shared_busy_q <= 1'b0;
         shared_idx_q <= 5'h00;
      end
      else
      begin
         // Set wins over either clear
         line_req_q <= (line_req_q & {3{~line_clr}}) | hit[2:0];
         group0_pending_q <= (group0_pending_q & ~group0_clr & g0_en)
                             | hit[11:3];
         if (!shared_busy_q && shared_pick[5])
         begin
            shared_busy_q <= 1'b1;
            shared_idx_q <= shared_pick[4:0];
            shared_req_q <= 1'b1;
         end
         else
         begin
            if (shared_clr)
               shared_req_q <= 1'b0;
            if (shared_busy_q && !shared_req_q && shared_idle)
               shared_busy_q <= 1'b0;
         end
      end
   end

   // Read data registered one cycle after sbus_rd
   always @*
   begin
      case (sbus_addr)
         `EIPS_ADDR_MAIN: rd_d = sel_main_q;
         `EIPS_ADDR_G0: rd_d = sel_g0_q;
         `EIPS_ADDR_G4_LOW: rd_d = sel_g4l_q;
         `EIPS_ADDR_G4_MID: rd_d = sel_g4m_q;
         `EIPS_ADDR_G4_HIGH: rd_d = sel_g4h_q;
         `EIPS_ADDR_POL1: rd_d = pol1_q;
         `EIPS_ADDR_POL2: rd_d = {5'h00, pol2_q};
         default: rd_d = 8'h00;
      endcase
   end

   always @(posedge clk_sys)
   begin
      if (!nrst)
      begin
         sbus_rdata_q <= 8'h00;
         line_pin_enable_q <= 3'h0;
         group0_member_enable_q <= 9'h000;
         shared_group_pin_enable_q <= 23'h00_0000;
      end
      else
      begin
         if (sbus_rd)
            sbus_rdata_q <= rd_d;
         line_pin_enable_q <= line_en;
         group0_member_enable_q <= g0_en;
         shared_group_pin_enable_q <= shared_en;
      end
   end
endmodule // eips_top
`default_nettype wire

// ---- rtl/eips_consts.vh ----
/*
 Constants for the external interrupt pin selection block: register
 offsets on the secondary bus, reset values, field positions and
 polarity codes. Assumes an 8-bit secondary bus with byte addresses.
*/
`ifndef EIPS_CONSTS_VH
`define EIPS_CONSTS_VH

`define EIPS_ADDR_MAIN 8'h34
`define EIPS_ADDR_G0 8'h35
`define EIPS_ADDR_G4_LOW 8'h36
`define EIPS_ADDR_G4_MID 8'h37
`define EIPS_ADDR_G4_HIGH 8'h38
`define EIPS_ADDR_POL1 8'h39
`define EIPS_ADDR_POL2 8'h3a

`define EIPS_RST_MAIN 8'h10
`define EIPS_RST_G0 8'h00
`define EIPS_RST_G4_LOW 8'h00
`define EIPS_RST_G4_MID 8'h00
`define EIPS_RST_G4_HIGH 8'h00
`define EIPS_RST_POL1 8'h55
`define EIPS_RST_POL2 8'h01

`define EIPS_MASK_G4_LOW 8'h80
`define EIPS_MASK_G4_MID 8'h87
`define EIPS_MASK_G4_HIGH 8'h7f
`define EIPS_MASK_POL2 8'h07

`define EIPS_POL_FALL 2'h1
`define EIPS_POL_RISE 2'h2

`define EIPS_BIT_LINE3 3
`define EIPS_BIT_LINE2 2
`define EIPS_BIT_LINE1 1
`define EIPS_BIT_G0P8 0
`define EIPS_BIT_G4_POL 2

`endif

// ---- rtl/eips_edge.v ----
/*
 Gated edge detector for one external interrupt input.
 Assumes the pin input is already synchronised to clk_sys.
*/
`timescale 1ns/10ps
`default_nettype none
`include "eips_consts.vh"
module eips_edge
(
   // Clock and reset
   input wire clk_sys,
   input wire nrst,
   // Pin and control
   input wire pin_sync,
   input wire enable,
   input wire [1:0] polarity,
   // Result
   output reg hit
);
   reg prev_q;
   wire rise;
   wire fall;

   assign rise = pin_sync & ~prev_q;
   assign fall = ~pin_sync & prev_q;

   // Keep history while disabled so enabling mid-level makes no edge
   always @(posedge clk_sys)
   begin
      if (!nrst)
         prev_q <= 1'b0;
      else
         prev_q <= pin_sync;
   end

   always @*
   begin
      case (polarity)
         `EIPS_POL_FALL: hit = enable & fall;
         `EIPS_POL_RISE: hit = enable & rise;
         default: hit = enable & (rise | fall);
      endcase
   end
endmodule // eips_edge
`default_nettype wire

// ---- test/eips_top_props.sv ----
/* Checker for eips_top: select writes and pin gating.
   Assumes one clock and a sync active-low reset. */
`timescale 1ns/10ps
`default_nettype none
module eips_top_props
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // Bus
   input wire logic [7:0] sbus_addr,
   input wire logic sbus_wr,
   input wire logic [7:0] sbus_wdata,
   // Enables and flags
   input wire logic [3:1] line_pin_enable_q,
   input wire logic [8:0] group0_member_enable_q,
   input wire logic [22:0] shared_group_pin_enable_q,
   input wire logic [3:1] line_req_q,
   input wire logic [8:0] group0_pending_q,
   input wire logic shared_req_q
);
   default clocking dc @(posedge clk_sys);
   endclocking
   default disable iff (!nrst);
   wire logic [7:0] wa = sbus_wr ? sbus_addr : 8'h00;
   // The select register takes the write at the sampling edge and the
   // routed enable outputs copy it one edge later
   line_sel_a:
   assert property (wa == 8'h34 |-> ##2
      line_pin_enable_q == $past(sbus_wdata[3:1], 2))
      else $error("line select");
   g0_pin8_a:
   assert property (wa == 8'h34 |-> ##2
      group0_member_enable_q[8] == $past(sbus_wdata[0], 2))
      else $error("pin8 select");
   g0_sel_a:
   assert property (wa == 8'h35 |-> ##2
      group0_member_enable_q[7:0] == $past(sbus_wdata, 2))
      else $error("group0 select");
   g4_low_a:
   assert property (wa == 8'h36 |-> ##2
      shared_group_pin_enable_q[7:0] == {$past(sbus_wdata[7], 2), 7'h00})
      else $error("shared low");
   g4_mid_a:
   assert property (wa == 8'h37 |-> ##2
      shared_group_pin_enable_q[15:8] == ($past(sbus_wdata, 2) & 8'h87))
      else $error("shared mid");
   g4_high_a:
   assert property (wa == 8'h38 |-> ##2
      shared_group_pin_enable_q[22:16] == $past(sbus_wdata[6:0], 2))
      else $error("shared high");
   g0_clear_a:
   assert property ($fell(group0_member_enable_q[0]) |=> !group0_pending_q[0])
      else $error("pending kept");
   line_off_a:
   assert property ((line_pin_enable_q == 3'h0) [*4] |->
      (line_req_q & ~$past(line_req_q)) == 3'h0)
      else $error("line request while off");
   shared_off_a:
   assert property ((shared_group_pin_enable_q == 23'h00_0000) [*4] |->
      !$rose(shared_req_q))
      else $error("shared request while off");
   cover property (wa == 8'h34);
   cover property ($rose(shared_req_q));
   cover property ($fell(group0_pending_q[0]));
endmodule // eips_top_props
bind eips_top eips_top_props i_eips_top_props (.*);
`default_nettype wire

// ---- test/eips_pins.sv ----
/* Pin-side model: idle-high interrupt pins, one pulled low on command.
   Assumes commands change just after a rising edge. */
`timescale 1ns/10ps
`default_nettype none
module eips_pins
(
   // Clock
   input wire logic clk_sys,
   // Command
   input wire logic go,
   input wire logic [5:0] sel,
   input wire logic [3:0] hold,
   // Pins
   output logic [3:1] line_pins,
   output logic [8:0] group0_pins,
   output logic [22:0] shared_group_inputs
);
   logic [34:0] lvl = 35'h7_ffff_ffff;
   logic [3:0] cnt = 4'h0;
   // Pull-ups: a released pin reads high
   assign {shared_group_inputs, group0_pins, line_pins} = lvl;
   always @(posedge clk_sys)
      if (go)
      begin
         lvl[sel] <= 1'b0;
         cnt <= hold;
      end
      else if (cnt != 4'h0)
         cnt <= cnt - 4'h1;
      else
         lvl <= 35'h7_ffff_ffff;
endmodule // eips_pins
`default_nettype wire

// ---- test/eips_top_tb.sv ----
/* Bench for eips_top: reset values, readback, gating, polarity.
   Assumes eips_pins on the pins and the bound checker. */
`timescale 1ns/10ps
`default_nettype none
module eips_top_tb;
   logic clk_sys = 1'b0;
   logic nrst = 1'b0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic go = 1'b0;
   logic snap = 1'b0;
   logic clr = 1'b0;
   logic [7:0] a = 8'h00;
   logic [7:0] d = 8'h00;
   logic [7:0] rx = 8'h00;
   logic [7:0] v;
   logic [5:0] sel = 6'h00;
   logic [3:0] hold = 4'h0;
   logic [34:0] fl = 35'h0_0000_0000;
   logic [7:0] m [0:6] = '{8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h55, 8'h01};
   logic [7:0] mk [0:6] = '{8'hff, 8'hff, 8'h80, 8'h87, 8'h7f, 8'hff, 8'h07};
   logic [55:0] q [$];
   int miscompares = 0;
   int samples_checked = 0;
   int unsigned rnd;
   wire [34:0] en;
   wire [3:1] lp, le, lq;
   wire [8:0] gp, ge, gq;
   wire [22:0] sp, se;
   wire sq;
   wire [7:0] rdq;
   assign en = {m[4][6:0], m[3][7], 4'h0, m[3][2:0], m[2][7], 7'h00,
      m[0][0], m[1], m[0][3:1]};
   always #20 clk_sys = ~clk_sys;
   eips_pins i_eips_pins (.clk_sys(clk_sys), .go(go), .sel(sel),
      .hold(hold), .line_pins(lp), .group0_pins(gp),
      .shared_group_inputs(sp));
   eips_top i_eips_top (.clk_sys(clk_sys), .nrst(nrst), .sbus_addr(a),
      .sbus_wr(wr), .sbus_rd(rd), .sbus_wdata(d), .sbus_rdata_q(rdq),
      .group0_clr({9{clr}}), .line_clr(clr), .shared_clr(clr),
      .line_pins(lp), .group0_pins(gp), .shared_group_inputs(sp),
      .line_pin_enable_q(le), .group0_member_enable_q(ge),
      .shared_group_pin_enable_q(se), .line_req_q(lq),
      .group0_pending_q(gq), .shared_req_q(sq));
   task automatic cmp(input logic [55:0] seen, input logic [55:0] want);
      samples_checked++;
      if (seen !== want)
      begin
         miscompares++;
         $display("CHECK FAILED %0t seen %h want %h", $time, seen, want);
      end
   endtask
   task automatic chk;
      @(posedge clk_sys);
      q.push_back({en[2:0], en[11:3], en[34:12], fl[2:0], fl[11:3],
         |fl[34:12], rx});
      snap <= 1'b1;
      @(posedge clk_sys);
      snap <= 1'b0;
   endtask
   task automatic acc(input int ad, input logic w, input logic [7:0] dd);
      @(posedge clk_sys);
      a <= ad[7:0];
      wr <= w;
      rd <= !w;
      d <= dd;
      @(posedge clk_sys);
      wr <= 1'b0;
      rd <= 1'b0;
      if (!w)
         rx = (ad > 'h33 && ad < 'h3b) ? m[ad-'h34] : 8'h00;
      else if (ad > 'h33 && ad < 'h3b)
         m[ad-'h34] = dd & mk[ad-'h34];
      if (w && ad == 'h35)
         fl[10:3] = fl[10:3] & dd;
      if (w && ad == 'h34)
         fl[11] = fl[11] & dd[0];
      chk;
   endtask
   task automatic pulse(input int s, input int h, input logic f);
      @(posedge clk_sys);
      sel <= s[5:0];
      hold <= h[3:0];
      go <= 1'b1;
      @(posedge clk_sys);
      go <= 1'b0;
      repeat (4) @(posedge clk_sys);
      if (f)
         fl[s] = fl[s] | en[s];
      chk;
   endtask
   task automatic clear;
      @(posedge clk_sys);
      clr <= 1'b1;
      @(posedge clk_sys);
      clr <= 1'b0;
      fl = 35'h0_0000_0000;
   endtask
   task automatic results;
      $display("checked %0d miscompares %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   always @(negedge clk_sys)
      if (snap)
         cmp({le, ge, se, lq, gq, sq, rdq}, q.pop_front());
   initial
   begin
      rnd = $urandom(20);
      repeat (3) @(posedge clk_sys);
      nrst <= 1'b1;
      for (int i = 'h33; i < 'h3c; i++)
         acc(i, 1'b0, 8'h00);
      $display("reset values done");
      repeat (3)
         for (int i = 'h34; i < 'h3c; i++)
         begin
            acc(i, 1'b1, 8'($urandom));
            acc(i, 1'b0, 8'h00);
         end
      acc('h39, 1'b1, 8'h55);
      acc('h3a, 1'b1, 8'h01);
      $display("readback done");
      for (int k = 0; k < 3; k++)
      begin
         v = k == 0 ? 8'hff : k == 1 ? 8'h00 : 8'($urandom);
         for (int i = 'h34; i < 'h39; i++)
            acc(i, 1'b1, v);
         for (int s = 0; s < 35; s++)
         begin
            pulse(s, 1, 1'b1);
            clear;
         end
      end
      $display("pin gating done");
      acc('h34, 1'b1, 8'h01);
      acc('h35, 1'b1, 8'h01);
      pulse(3, 1, 1'b1);
      pulse(11, 1, 1'b1);
      acc('h35, 1'b1, 8'h00);
      acc('h34, 1'b1, 8'h00);
      acc('h35, 1'b1, 8'h01);
      for (int c = 0; c < 4; c++)
      begin
         acc('h3a, 1'b1, c[7:0]);
         pulse(3, 8, c != 2);
         repeat (7) @(posedge clk_sys);
         fl[3] = en[3];
         chk;
         clear;
      end
      $display("polarity done");
      results;
   end
endmodule // eips_top_tb
`default_nettype wire
